/* skbi_pkg.sv */
// Package: constants, register map and types of the skip/branch/or/increment execution block
package skbi_pkg;

  // ****************************************************************
  // Widths and depths
  // ****************************************************************
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FADDR_W    = 7;
  localparam int unsigned FILE_DEPTH = 128;
  localparam int unsigned IMM_W      = 11;
  localparam int unsigned PC_W       = 13;
  localparam int unsigned PCH_W      = 5;
  localparam int unsigned PCH_BR_HI  = 4;
  localparam int unsigned PCH_BR_LO  = 3;
  localparam int unsigned CYC_W      = 32;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFFS_INSTR  = 8'h00;
  localparam logic [7:0] OFFS_ACC    = 8'h04;
  localparam logic [7:0] OFFS_STATUS = 8'h08;
  localparam logic [7:0] OFFS_PCH    = 8'h0C;
  localparam logic [7:0] OFFS_PC     = 8'h10;
  localparam logic [7:0] OFFS_CYCLES = 8'h14;
  localparam logic [7:0] OFFS_FADDR  = 8'h18;
  localparam logic [7:0] OFFS_FDATA  = 8'h1C;

  // ****************************************************************
  // Status field positions
  // ****************************************************************
  localparam int unsigned STAT_ZERO_BIT = 0;
  localparam int unsigned STAT_SKIP_BIT = 1;
  localparam int unsigned STAT_BUSY_BIT = 2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
  localparam logic [DATA_W-1:0]  FILE_RST  = 8'h00;
  localparam logic [PC_W-1:0]    PC_RST    = 13'h0000;
  localparam logic [PCH_W-1:0]   PCH_RST   = 5'h00;
  localparam logic [FADDR_W-1:0] FADDR_RST = 7'h00;
  localparam logic [CYC_W-1:0]   CYC_RST   = 32'h00000000;
  localparam logic [31:0]        WORD_RST  = 32'h00000000;
  localparam logic               RESP_OKAY = 1'b0;

  // ****************************************************************
  // Timing counts in instruction cycles
  // ****************************************************************
  localparam logic [CYC_W-1:0] TCY_ONE = 32'h00000001;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_NOP      = 3'b000,
    OP_DEC_SKIP = 3'b001,
    OP_INC_SKIP = 3'b010,
    OP_BRANCH   = 3'b011,
    OP_OR_LIT   = 3'b100,
    OP_INC      = 3'b101,
    OP_OR_FILE  = 3'b110
  } skbi_op_t;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_DATA  = 2'b01,
    BUS_STALL = 2'b10
  } skbi_bus_t;

  typedef struct packed {
    logic [4:0]         rsvd_a;
    logic [IMM_W-1:0]   imm;
    logic               rsvd_b;
    logic [FADDR_W-1:0] faddr;
    logic [3:0]         rsvd_c;
    logic               dest;
    skbi_op_t           op;
  } skbi_instr_t;

  typedef struct packed {
    logic [7:0] offs;
    logic       write;
  } skbi_req_t;

endpackage : skbi_pkg

/* skbi_exec.sv */
// Module: instruction execution core with AHB-Lite register slave
// Contract
// (RULE1) 7-bit file address picks operand; dest 0 writes accumulator, 1 writes file.
// (RULE2) Decrement-skip subtracts one, stores at destination, flags untouched.
// (RULE3) Zero decrement result turns next instruction into a no-op, two cycles.
// (RULE4) Increment-skip adds one, flags untouched, zero result skips next instruction.
// (RULE5) Branch loads 11-bit immediate into pc[10:0], latch bits 4:3 into pc[12:11].
// (RULE6) Branch takes two instruction cycles, flags untouched.
// (RULE7) Or-literal ORs accumulator with 8-bit literal into accumulator, updates zero.
// (RULE8) Increment adds one, stores at destination, updates zero, never skips.
// (RULE9) Or-file ORs accumulator with file register into destination, updates zero.
// (RULE10) Data paths are 8 bits; increment and decrement wrap modulo 256.
`timescale 1ns/10ps
module skbi_exec
  import skbi_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);
  import skbi_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  skbi_bus_t                       state_r;
  skbi_req_t                       req_r;
  logic             [31:0]         hrdata_r;
  logic                            hreadyout_r;
  logic                            hresp_r;
  logic             [DATA_W-1:0]   acc_r;
  logic                            zero_r;
  logic                            skip_r;
  logic             [PC_W-1:0]     pc_r;
  logic             [PCH_W-1:0]    pch_r;
  logic             [CYC_W-1:0]    cyc_r;
  logic             [FADDR_W-1:0]  faddr_r;
  logic             [31:0]         last_instr_r;
  logic             [DATA_W-1:0]   file_r [FILE_DEPTH];

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic                            accept;
  logic                            dphase;
  logic                            sw_wr;
  logic                            exec_go;
  skbi_instr_t                     ins;
  skbi_op_t                        eff_op;
  logic             [DATA_W-1:0]   operand;
  logic             [DATA_W-1:0]   res;
  logic                            wr_acc;
  logic                            wr_file;
  logic                            upd_zero;
  logic                            set_skip;
  logic                            branch;
  logic             [PC_W-1:0]     pc_nxt;
  logic             [31:0]         rd_nxt;

  assign accept  = hsel && htrans[1] && hready && (state_r == BUS_IDLE);
  assign dphase  = (state_r == BUS_DATA);
  assign sw_wr   = dphase && req_r.write;
  assign exec_go = sw_wr && (req_r.offs == OFFS_INSTR);
  assign ins     = skbi_instr_t'(hwdata);
  assign eff_op  = skip_r ? OP_NOP : ins.op;
  assign operand = file_r[ins.faddr]; // RULE1

  // ****************************************************************
  // Execution datapath
  // ****************************************************************
  always_comb
  begin
    res      = operand;
    wr_acc   = 1'b0;
    wr_file  = 1'b0;
    upd_zero = 1'b0;
    set_skip = 1'b0;
    branch   = 1'b0;
    case (eff_op)
      OP_DEC_SKIP:
      begin
        res      = operand - 8'h01; // RULE2 RULE10
        wr_acc   = !ins.dest; // RULE1
        wr_file  = ins.dest; // RULE1
        set_skip = (res == 8'h00); // RULE3
      end
      OP_INC_SKIP:
      begin
        res      = operand + 8'h01; // RULE4 RULE10
        wr_acc   = !ins.dest;
        wr_file  = ins.dest;
        set_skip = (res == 8'h00); // RULE4
      end
      OP_BRANCH: branch = 1'b1; // RULE6
      OP_OR_LIT:
      begin
        res      = acc_r | ins.imm[DATA_W-1:0]; // RULE7
        wr_acc   = 1'b1;
        upd_zero = 1'b1;
      end
      OP_INC:
      begin
        res      = operand + 8'h01; // RULE8 RULE10
        wr_acc   = !ins.dest;
        wr_file  = ins.dest;
        upd_zero = 1'b1;
      end
      OP_OR_FILE:
      begin
        res      = acc_r | operand; // RULE9
        wr_acc   = !ins.dest;
        wr_file  = ins.dest;
        upd_zero = 1'b1;
      end
      default: res = operand;
    endcase
  end

  assign pc_nxt = branch ? {pch_r[PCH_BR_HI:PCH_BR_LO], ins.imm} : pc_r + 13'h0001; // RULE5

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  always_comb
  begin
    rd_nxt = WORD_RST;
    case (req_r.offs)
      OFFS_INSTR:  rd_nxt = last_instr_r;
      OFFS_ACC:    rd_nxt = {24'h000000, acc_r};
      OFFS_STATUS: rd_nxt = {29'h00000000, 1'b0, skip_r, zero_r};
      OFFS_PCH:    rd_nxt = {27'h0000000, pch_r};
      OFFS_PC:     rd_nxt = {19'h00000, pc_r};
      OFFS_CYCLES: rd_nxt = cyc_r;
      OFFS_FADDR:  rd_nxt = {25'h0000000, faddr_r};
      OFFS_FDATA:  rd_nxt = {24'h000000, file_r[faddr_r]};
      default:     rd_nxt = WORD_RST;
    endcase
  end

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r     <= BUS_IDLE;
      req_r       <= '0;
      hreadyout_r <= 1'b1;
      hresp_r     <= RESP_OKAY;
    end
    else
    begin
      hresp_r <= RESP_OKAY;
      case (state_r)
        BUS_IDLE:
        begin
          if (accept)
          begin
            req_r       <= '{offs: haddr[7:0], write: hwrite};
            state_r     <= BUS_DATA;
            hreadyout_r <= 1'b0;
          end
        end
        BUS_DATA:
        begin
          if (exec_go && branch)
          begin
            state_r <= BUS_STALL; // RULE6
          end
          else
          begin
            state_r     <= BUS_IDLE;
            hreadyout_r <= 1'b1;
          end
        end
        default: // RULE6
        begin
          state_r     <= BUS_IDLE;
          hreadyout_r <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= WORD_RST;
    else if (dphase && !req_r.write)
      hrdata_r <= rd_nxt;
  end

  // ****************************************************************
  // Accumulator and zero flag
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      acc_r <= ACC_RST;
    end
    else if (exec_go && wr_acc)
    begin
      acc_r <= res; // RULE1
    end
    else if (sw_wr && (req_r.offs == OFFS_ACC))
    begin
      acc_r <= hwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      zero_r <= 1'b0;
      skip_r <= 1'b0;
    end
    else if (exec_go)
    begin
      if (upd_zero)
      begin
        zero_r <= (res == 8'h00); // RULE7 RULE8 RULE9
      end
      skip_r <= set_skip; // RULE3 RULE4
    end
    else if (sw_wr && (req_r.offs == OFFS_STATUS))
    begin
      zero_r <= hwdata[STAT_ZERO_BIT];
      skip_r <= hwdata[STAT_SKIP_BIT];
    end
  end

  // ****************************************************************
  // Program counter and high latch
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pc_r <= PC_RST;
    end
    else if (exec_go)
    begin
      pc_r <= pc_nxt; // RULE5
    end
    else if (sw_wr && (req_r.offs == OFFS_PC))
    begin
      pc_r <= hwdata[PC_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pch_r <= PCH_RST;
    else if (sw_wr && (req_r.offs == OFFS_PCH))
      pch_r <= hwdata[PCH_W-1:0];
  end

  // ****************************************************************
  // Instruction cycle counter and last instruction
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cyc_r <= CYC_RST;
    end
    else if (exec_go || (state_r == BUS_STALL))
    begin
      cyc_r <= cyc_r + TCY_ONE; // RULE3 RULE6
    end
    else if (sw_wr && (req_r.offs == OFFS_CYCLES))
    begin
      cyc_r <= CYC_RST;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      last_instr_r <= WORD_RST;
    else if (exec_go)
      last_instr_r <= hwdata;
  end

  // ****************************************************************
  // File registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      faddr_r <= FADDR_RST;
    else if (sw_wr && (req_r.offs == OFFS_FADDR))
      faddr_r <= hwdata[FADDR_W-1:0];
  end

  for (genvar gi = 0; gi < FILE_DEPTH; gi++)
  begin : g_file
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        file_r[gi] <= FILE_RST;
      end
      else if (exec_go && wr_file && (ins.faddr == FADDR_W'(gi)))
      begin
        file_r[gi] <= res; // RULE1
      end
      else if (sw_wr && (req_r.offs == OFFS_FDATA) && (faddr_r == FADDR_W'(gi)))
      begin
        file_r[gi] <= hwdata[DATA_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;

endmodule : skbi_exec

/* skbi_monitor.sv */
// Bus timing and read-format checker for the execution block
`timescale 1ns/10ps
module skbi_monitor
  import skbi_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp
);
  // ****************************************************************
  // Transfer decode
  // ****************************************************************
  logic tk;
  logic rd;
  assign tk = hsel && htrans[1] && hready && hreadyout;
  assign rd = tk && !hwrite;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ****************************************************************
  // Sequences
  // ****************************************************************
  sequence s_wait1;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_wait2;
    !hreadyout ##1 s_wait1;
  endsequence
  sequence s_rd(logic [7:0] o);
    rd && haddr[7:0] == o ##1 s_wait1;
  endsequence
  sequence s_wr_op(logic br);
    tk && hwrite && haddr[7:0] == OFFS_INSTR ##1 (hwdata[2:0] == 3'h3) == br;
  endsequence
  property p_clean(logic [7:0] o, logic [31:0] m);
    s_rd(o) |-> (hrdata & m) == 32'h00000000;
  endproperty

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_resp_okay:
    assert property (hresp == RESP_OKAY) else $error("error response seen");
  a_read_wait:
    assert property (rd |=> s_wait1) else $error("read wait not one cycle");
  a_exec_one:
    assert property (s_wr_op(1'h0) |-> s_wait1) else $error("instruction wait not one cycle");
  a_branch_two:
    assert property (s_wr_op(1'h1) |-> s_wait2) else $error("branch wait not two cycles");
  a_idle_ready:
    assert property (hreadyout && !tk |=> hreadyout) else $error("wait state without transfer");
  a_hold_rdata:
    assert property ($changed(hrdata) |-> $past(rd, 2)) else $error("read data changed outside read");
  a_unmap_zero:
    assert property (rd && haddr[7:0] >= 8'h20 |=> s_wait1 ##0 hrdata == 32'h00000000)
      else $error("unmapped read not zero");
  a_acc_clean:
    assert property (p_clean(OFFS_ACC, 32'hFFFFFF00)) else $error("accumulator upper bits set");
  a_pc_clean:
    assert property (p_clean(OFFS_PC, 32'hFFFFE000)) else $error("counter upper bits set");
  a_stat_clean:
    assert property (p_clean(OFFS_STATUS, 32'hFFFFFFFC)) else $error("status spare bits set");
endmodule : skbi_monitor

bind skbi_exec skbi_monitor skbi_monitor_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp)
);

/* test_skbi_exec.sv */
// Directed register-level testbench for the execution block
`timescale 1ns/10ps
module test_skbi_exec;
  import skbi_pkg::*;
  logic        hclk = 1'h0;
  logic        hresetn = 1'h0;
  logic        hsel = 1'h0;
  logic        hwrite = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hrdata;
  logic [31:0] d;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  int          mismatches = 0;
  int          checks = 0;

  assign hready = hreadyout;
  always #25 hclk = ~hclk;

  skbi_exec skbi_exec_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp)
  );

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'h1;
    hwrite <= w;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    d = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xfer(1'h1, a, v);
  endtask : wr

  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    checks++;
    if (d !== e)
    begin
      mismatches++;
      $display("[FAIL] t=%0t reg %h got %h exp %h", $time, a, d, e);
    end
  endtask : chk

  task automatic ex(input skbi_op_t op, input logic ds, input logic [6:0] f, input logic [10:0] k);
    wr(OFFS_INSTR, {5'h00, k, 1'h0, f, 4'h0, ds, op});
  endtask : ex

  task automatic setf(input logic [6:0] f, input logic [31:0] v);
    wr(OFFS_FADDR, {25'h0, f});
    wr(OFFS_FDATA, v);
  endtask : setf

  task automatic chkf(input logic [6:0] f, input logic [31:0] e);
    wr(OFFS_FADDR, {25'h0, f});
    chk(OFFS_FDATA, e);
  endtask : chkf

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    #100000;
    mismatches++;
    end_sim;
  end

  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    chk(OFFS_ACC, {24'h0, ACC_RST});
    chk(OFFS_PC, {19'h0, PC_RST});
    chk(OFFS_CYCLES, CYC_RST);
    setf(7'h05, 32'h01);
    wr(OFFS_ACC, 32'hAA);
    wr(OFFS_STATUS, 32'h1);
    ex(OP_DEC_SKIP, 1'h1, 7'h05, 11'h000);
    chkf(7'h05, 32'h00);
    chk(OFFS_ACC, 32'hAA);
    chk(OFFS_STATUS, 32'h3);
    ex(OP_OR_LIT, 1'h0, 7'h00, 11'h00F);
    chk(OFFS_ACC, 32'hAA);
    chk(OFFS_STATUS, 32'h1);
    chk(OFFS_PC, 32'h2);
    chk(OFFS_CYCLES, 32'h2);
    ex(OP_DEC_SKIP, 1'h0, 7'h05, 11'h000);
    chk(OFFS_ACC, 32'hFF);
    chk(OFFS_STATUS, 32'h1);
    chkf(7'h05, 32'h00);
    setf(7'h7F, 32'hFF);
    wr(OFFS_STATUS, 32'h0);
    ex(OP_INC_SKIP, 1'h0, 7'h7F, 11'h000);
    chk(OFFS_ACC, 32'h00);
    chk(OFFS_STATUS, 32'h2);
    ex(OP_INC, 1'h1, 7'h7F, 11'h000);
    chkf(7'h7F, 32'hFF);
    ex(OP_INC, 1'h1, 7'h7F, 11'h000);
    chkf(7'h7F, 32'h00);
    chk(OFFS_STATUS, 32'h1);
    ex(OP_INC, 1'h0, 7'h7F, 11'h000);
    chk(OFFS_ACC, 32'h01);
    chk(OFFS_STATUS, 32'h0);
    wr(OFFS_ACC, 32'h00);
    ex(OP_OR_LIT, 1'h1, 7'h00, 11'h000);
    chk(OFFS_STATUS, 32'h1);
    wr(OFFS_ACC, 32'h50);
    ex(OP_OR_LIT, 1'h0, 7'h00, 11'h70A);
    chk(OFFS_ACC, 32'h5A);
    chk(OFFS_STATUS, 32'h0);
    wr(OFFS_ACC, 32'h30);
    setf(7'h40, 32'h03);
    ex(OP_OR_FILE, 1'h1, 7'h40, 11'h000);
    chkf(7'h40, 32'h33);
    chk(OFFS_FADDR, 32'h40);
    chk(OFFS_ACC, 32'h30);
    wr(OFFS_ACC, 32'h00);
    setf(7'h01, 32'h00);
    ex(OP_OR_FILE, 1'h0, 7'h01, 11'h000);
    chk(OFFS_STATUS, 32'h1);
    wr(OFFS_PCH, 32'h17);
    wr(OFFS_CYCLES, 32'h0);
    ex(OP_BRANCH, 1'h0, 7'h00, 11'h7FF);
    chk(OFFS_PC, 32'h17FF);
    chk(OFFS_CYCLES, 32'h2);
    chk(OFFS_STATUS, 32'h1);
    chk(OFFS_INSTR, 32'h07FF0003);
    chk(OFFS_PCH, 32'h17);
    wr(OFFS_PCH, 32'h08);
    ex(OP_BRANCH, 1'h0, 7'h00, 11'h000);
    chk(OFFS_PC, 32'h0800);
    ex(skbi_op_t'(3'h7), 1'h0, 7'h00, 11'h000);
    chk(OFFS_PC, 32'h0801);
    setf(7'h10, 32'h41);
    ex(OP_INC_SKIP, 1'h1, 7'h10, 11'h000);
    chkf(7'h10, 32'h42);
    chk(OFFS_STATUS, 32'h1);
    wr(8'h24, 32'hFFFFFFFF);
    chk(8'h24, 32'h0);
    end_sim;
  end
endmodule : test_skbi_exec
